/* common/mmcg_pkg.sv */
// package for the multi-mode clock generator mode control
// assumes a single ref_clk domain; clock sources arrive as sampled pin levels
package mmcg_pkg;

  localparam logic [1:0] CLKSRC_LOOP = 2'h0;
  localparam logic [1:0] CLKSRC_INT = 2'h1;
  localparam logic [1:0] CLKSRC_EXT = 2'h2;
  localparam logic [2:0] REFDIV_RESET = 3'h0;
  localparam logic [1:0] BUSDIV_RESET = 2'h1;
  localparam logic [3:0] VCOMUL_RESET = 4'h1;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic FINETRIM_RESET = 1'b0;
  localparam int FLL_FACTOR = 1024;
  localparam logic [3:0] VCOMUL_MAX_CODE = 4'hA;
  localparam logic [5:0] VCOMUL_STEP = 6'h04;
  localparam logic [5:0] VCOMUL_DEFAULT = 6'h28;
  // loss-of-clock watchdog, in ref_clk cycles without an external edge
  localparam logic [15:0] LOSS_LIMIT_HIGH = 16'h0040;
  localparam logic [15:0] LOSS_LIMIT_LOW = 16'h1000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef enum logic [7:0] {
    MMCG_FEI  = 8'h01,
    MMCG_FEE  = 8'h02,
    MMCG_FBI  = 8'h04,
    MMCG_FBE  = 8'h08,
    MMCG_PEE  = 8'h10,
    MMCG_PBE  = 8'h20,
    MMCG_LOW_POWER_INTERNAL_MODE = 8'h40,
    MMCG_LOW_POWER_EXTERNAL_MODE = 8'h80
  } mmcg_mode_t;

  typedef struct packed {
    logic [1:0] clockSourceSelect;
    logic referenceSelect;
    logic loopSelect;
    logic lowPowerBit;
    logic [2:0] referenceDivider;
    logic [1:0] busDivider;
    logic [3:0] vcoMultiplierField;
    logic internalRefOutEnable;
    logic internalRefStopEnable;
    logic externalRefOutEnable;
    logic externalRefStopEnable;
    logic clockMonitorEnable;
    logic rangeHigh;
  } mmcg_ctrl_t;

  typedef struct packed {
    logic fllEnable;
    logic pllEnable;
    logic fllLinkMode;
    logic dcoHalfLink;
    logic fllUsesExternal;
    logic pllUsesExternal;
    logic [5:0] pllMultiplier;
    logic [2:0] refDivider;
  } mmcg_loop_t;

endpackage

/* core/mmcg_glitch_mux.sv */
// glitch-free two-stage select handover for the output clock
// assumes source-ready levels are already synchronised to ref_clk
module mmcg_glitch_mux
  import mmcg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // request
  input wire logic [1:0] requestSel,
  input wire logic [2:0] sourceReady,
  // status
  output logic [1:0] activeSel
);
  logic [1:0] activeSel_ff;
  logic [1:0] pendSel_ff;
  logic gateOff_ff;

  assign activeSel = activeSel_ff;

  // old source gated off one cycle before new one is released: no runt pulse
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      activeSel_ff <= CLKSRC_LOOP;
      pendSel_ff <= CLKSRC_LOOP;
      gateOff_ff <= 1'b0;
    end else if (gateOff_ff) begin
      activeSel_ff <= pendSel_ff;
      gateOff_ff <= 1'b0;
    end else if (requestSel != activeSel_ff && requestSel <= CLKSRC_EXT && sourceReady[requestSel]) begin
      pendSel_ff <= requestSel;
      gateOff_ff <= 1'b1;
    end
  end
endmodule

/* core/mmcg_mode_ctrl.sv */
// mode control for the multi-mode clock generator
// assumes control bits come from same-domain logic; pins are synchronised here
module mmcg_mode_ctrl
  import mmcg_pkg::*;
(
  // clock and resets
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic powerOnResetn,
  // control
  input wire mmcg_pkg::mmcg_ctrl_t ctrl,
  input wire logic debugActive,
  input wire logic chipStop,
  input wire logic trimWrite,
  input wire logic [7:0] trimWriteValue,
  input wire logic fineTrimWriteValue,
  // analog status pins
  input wire logic externalRefPin,
  input wire logic externalReadyPin,
  input wire logic loopLockPin,
  // loop controls
  output mmcg_pkg::mmcg_loop_t loopCtrl,
  output logic [1:0] outputSourceSel,
  output logic [1:0] busDividerOut,
  // clock gates
  output logic debugLinkClockEnable,
  output logic internalRefClockEnable,
  output logic externalRefClockEnable,
  output logic generatorClockEnable,
  // trim
  output logic [7:0] trimOut,
  output logic fineTrimOut,
  output logic outputFollowsTrim,
  // status
  output mmcg_pkg::mmcg_mode_t currentMode,
  output logic [1:0] clockSourceStatus,
  output logic referenceStatus,
  output logic loopSelectStatus,
  output logic lossOfClockReset,
  output logic lossOfClockFlag
);
  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  logic extRefLast_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinMeta_ff <= 3'h0;
      pinSync_ff <= 3'h0;
      extRefLast_ff <= 1'b0;
    end else begin
      pinMeta_ff <= {externalRefPin, externalReadyPin, loopLockPin};
      pinSync_ff <= pinMeta_ff;
      extRefLast_ff <= pinSync_ff[2];
    end
  end

  logic extRefSync;
  logic extReady;
  logic loopLocked;
  assign extRefSync = pinSync_ff[2];
  assign extReady = pinSync_ff[1];
  assign loopLocked = pinSync_ff[0];

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  // requested mode; illegal combinations keep the present mode
  function automatic mmcg_mode_t decodeMode(input mmcg_ctrl_t c, input logic dbg, input mmcg_mode_t cur);
    mmcg_mode_t m;
    m = cur;
    case (c.clockSourceSelect)
      CLKSRC_LOOP: begin
        if (c.referenceSelect && !c.loopSelect)
          m = MMCG_FEI;
        else if (!c.referenceSelect && !c.loopSelect)
          m = MMCG_FEE;
        else if (!c.referenceSelect && c.loopSelect)
          m = MMCG_PEE;
      end
      CLKSRC_INT: begin
        if (c.referenceSelect && c.lowPowerBit && !dbg)
          m = MMCG_LOW_POWER_INTERNAL_MODE;
        else if (c.referenceSelect && !c.loopSelect)
          m = MMCG_FBI;
      end
      CLKSRC_EXT: begin
        if (!c.referenceSelect && c.lowPowerBit && !dbg)
          m = MMCG_LOW_POWER_EXTERNAL_MODE;
        else if (!c.referenceSelect && !c.loopSelect)
          m = MMCG_FBE;
        else if (!c.referenceSelect && c.loopSelect)
          m = MMCG_PBE;
      end
      default: m = cur;
    endcase
    return m;
  endfunction

  // encoded multiplier; reserved codes fall back to the largest factor
  function automatic logic [5:0] vcoFactor(input logic [3:0] code);
    logic [5:0] f;
    f = VCOMUL_DEFAULT;
    if (code <= VCOMUL_MAX_CODE && code != 4'h0)
      f = 6'(code * VCOMUL_STEP);
    return f;
  endfunction

  function automatic logic usesExternal(input mmcg_mode_t m);
    return m == MMCG_FEE || m == MMCG_FBE || m == MMCG_PEE || m == MMCG_PBE || m == MMCG_LOW_POWER_EXTERNAL_MODE;
  endfunction

  // ------------------------------------------------------------
  // mode register and reference switch
  // ------------------------------------------------------------
  mmcg_mode_t mode_ff;
  mmcg_mode_t nxt_mode;
  logic refStatus_ff;
  logic loopSt_ff;
  logic inStop;

  assign inStop = chipStop;
  assign nxt_mode = decodeMode(ctrl, debugActive, mode_ff);

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      mode_ff <= MMCG_FEI;
    else if (!inStop)
      mode_ff <= nxt_mode;
  end

  // external switch only completes once the oscillator is ready
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      refStatus_ff <= 1'b1;
      loopSt_ff <= 1'b0;
    end else begin
      if (ctrl.referenceSelect)
        refStatus_ff <= 1'b1;
      else if (extReady)
        refStatus_ff <= 1'b0;
      loopSt_ff <= ctrl.loopSelect;
    end
  end

  // ------------------------------------------------------------
  // output clock select
  // ------------------------------------------------------------
  logic [1:0] muxStatus;
  logic [2:0] srcReady;
  logic [1:0] clockSourceStatus_ff;
  // loop source counts as available once locked or when already in use
  assign srcReady = {extReady, 1'b1, loopLocked || clockSourceStatus_ff == CLKSRC_LOOP};

  mmcg_glitch_mux uMux (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .requestSel(ctrl.clockSourceSelect),
    .sourceReady(srcReady),
    .activeSel(muxStatus)
  );

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      clockSourceStatus_ff <= CLKSRC_LOOP;
    else
      clockSourceStatus_ff <= muxStatus;
  end

  // ------------------------------------------------------------
  // loop controls
  // ------------------------------------------------------------
  mmcg_loop_t loop_ff;
  mmcg_loop_t nxt_loop;

  always_comb begin
    nxt_loop = '0;
    nxt_loop.refDivider = ctrl.referenceDivider;
    nxt_loop.pllMultiplier = vcoFactor(ctrl.vcoMultiplierField);
    case (mode_ff)
      MMCG_FEI, MMCG_FBI: begin
        nxt_loop.fllEnable = 1'b1;
        nxt_loop.fllLinkMode = 1'b1;
      end
      MMCG_FEE, MMCG_FBE: begin
        nxt_loop.fllEnable = 1'b1;
        nxt_loop.fllLinkMode = 1'b1;
        nxt_loop.fllUsesExternal = !ctrl.referenceSelect;
      end
      MMCG_PEE, MMCG_PBE: begin
        nxt_loop.pllEnable = 1'b1;
        nxt_loop.pllUsesExternal = !ctrl.referenceSelect;
        nxt_loop.dcoHalfLink = debugActive;
        nxt_loop.fllEnable = debugActive;
      end
      MMCG_LOW_POWER_INTERNAL_MODE, MMCG_LOW_POWER_EXTERNAL_MODE: nxt_loop.fllEnable = 1'b0;
      default: nxt_loop.fllEnable = 1'b0;
    endcase
    if (inStop)
      nxt_loop = '0;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      loop_ff <= '0;
    else
      loop_ff <= nxt_loop;
  end

  // ------------------------------------------------------------
  // clock gates and bus divider
  // ------------------------------------------------------------
  logic linkEn_ff;
  logic irEn_ff;
  logic erEn_ff;
  logic genEn_ff;
  logic [1:0] busDiv_ff;
  mmcg_mode_t preStopMode_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      preStopMode_ff <= MMCG_FEI;
    else if (!inStop)
      preStopMode_ff <= mode_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      linkEn_ff <= 1'b1;
      irEn_ff <= 1'b0;
      erEn_ff <= 1'b0;
      genEn_ff <= 1'b1;
    end else begin
      genEn_ff <= !inStop;
      linkEn_ff <= !inStop && mode_ff != MMCG_LOW_POWER_INTERNAL_MODE && mode_ff != MMCG_LOW_POWER_EXTERNAL_MODE
                   && (nxt_loop.fllLinkMode || nxt_loop.dcoHalfLink);
      irEn_ff <= ctrl.internalRefOutEnable && (!inStop || ctrl.internalRefStopEnable);
      erEn_ff <= ctrl.externalRefOutEnable && (!inStop || ctrl.externalRefStopEnable
                 || usesExternal(preStopMode_ff));
    end
  end

  // applied the cycle after it is written, regardless of status
  always_ff @(posedge ref_clk) begin
    if (!resetn)
      busDiv_ff <= BUSDIV_RESET;
    else
      busDiv_ff <= ctrl.busDivider;
  end

  // ------------------------------------------------------------
  // trim, kept across every reset but power-on; the follow flag is set again by resetn
  // ------------------------------------------------------------
  logic [7:0] trim_ff;
  logic fineTrim_ff;
  logic followTrim_ff;

  always_ff @(posedge ref_clk) begin
    if (!powerOnResetn) begin
      trim_ff <= TRIM_RESET;
      fineTrim_ff <= FINETRIM_RESET;
    end else if (trimWrite) begin
      trim_ff <= trimWriteValue;
      fineTrim_ff <= fineTrimWriteValue;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      followTrim_ff <= 1'b1;
    else
      followTrim_ff <= mode_ff == MMCG_FEI || mode_ff == MMCG_FBI || mode_ff == MMCG_LOW_POWER_INTERNAL_MODE;
  end

  // ------------------------------------------------------------
  // loss-of-clock monitor
  // ------------------------------------------------------------
  // edge-gap watchdog; limits stand in for the analog thresholds
  logic [15:0] gapCnt_ff;
  logic locReset_ff;
  logic locFlag_ff;
  logic extEdge;
  assign extEdge = extRefSync ^ extRefLast_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn || extEdge || !ctrl.clockMonitorEnable)
      gapCnt_ff <= '0;
    else if (gapCnt_ff != LOSS_LIMIT_LOW)
      gapCnt_ff <= gapCnt_ff + CNT_ONE;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      locReset_ff <= 1'b0;
    else
      locReset_ff <= ctrl.clockMonitorEnable && !inStop
                     && gapCnt_ff >= (ctrl.rangeHigh ? LOSS_LIMIT_HIGH : LOSS_LIMIT_LOW);
  end

  // flag survives the chip reset it causes; cleared only by power-on
  always_ff @(posedge ref_clk) begin
    if (!powerOnResetn)
      locFlag_ff <= 1'b0;
    else if (locReset_ff)
      locFlag_ff <= 1'b1;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign loopCtrl = loop_ff;
  assign outputSourceSel = clockSourceStatus_ff;
  assign busDividerOut = busDiv_ff;
  assign debugLinkClockEnable = linkEn_ff;
  assign internalRefClockEnable = irEn_ff;
  assign externalRefClockEnable = erEn_ff;
  assign generatorClockEnable = genEn_ff;
  assign trimOut = trim_ff;
  assign fineTrimOut = fineTrim_ff;
  assign outputFollowsTrim = followTrim_ff;
  assign currentMode = mode_ff;
  assign clockSourceStatus = clockSourceStatus_ff;
  assign referenceStatus = refStatus_ff;
  assign loopSelectStatus = loopSt_ff;
  assign lossOfClockReset = locReset_ff;
  assign lossOfClockFlag = locFlag_ff;
endmodule

/* verification/mmcg_ext_osc.sv */
// external crystal or clock source seen at the mode control pins
// assumes the bench decides when the source runs and when it has settled
module mmcg_ext_osc (
  // source control
  input wire logic oscRun,
  input wire logic oscStable,
  // pins
  output logic externalRefPin,
  output logic externalReadyPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // oscillator
  // ----
  // slower than ref_clk so the synchroniser sees every level; static when stopped
  // offset keeps every toggle away from a ref_clk edge
  initial begin
    externalRefPin = 1'b0;
    #1;
    forever #20 if (oscRun) externalRefPin = ~externalRefPin;
  end
  // ready drops with the source, never lingers from before
  assign externalReadyPin = oscRun && oscStable;
endmodule

/* verification/mmcg_checker.sv */
// timing checks on the mode control ports
// assumes one ref_clk domain and synchronous active-low resets
module mmcg_checker
  import mmcg_pkg::*;
(
  // clock and resets
  input wire logic ref_clk, resetn, powerOnResetn,
  // control
  input wire mmcg_pkg::mmcg_ctrl_t ctrl,
  input wire logic debugActive, chipStop, trimWrite, fineTrimWriteValue,
  input wire logic [7:0] trimWriteValue,
  input wire logic externalRefPin, externalReadyPin, loopLockPin,
  // outputs
  input wire mmcg_pkg::mmcg_loop_t loopCtrl,
  input wire logic [1:0] outputSourceSel, busDividerOut, clockSourceStatus,
  input wire logic debugLinkClockEnable, internalRefClockEnable, externalRefClockEnable,
  input wire logic generatorClockEnable, fineTrimOut, outputFollowsTrim, referenceStatus,
  input wire logic loopSelectStatus, lossOfClockReset, lossOfClockFlag,
  input wire logic [7:0] trimOut,
  input wire mmcg_pkg::mmcg_mode_t currentMode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----
  // assertions
  // ----
  reset_mode_a: assert property (disable iff (1'b0) !resetn |=> currentMode == MMCG_FEI)
    else $error("mode after reset wrong");
  fbe_entry_a: assert property (!chipStop && ctrl.clockSourceSelect == CLKSRC_EXT && !ctrl.referenceSelect
    && !ctrl.loopSelect && !ctrl.lowPowerBit |=> currentMode == MMCG_FBE) else $error("bypassed external missed");
  low_power_internal_mode_entry_a: assert property (!chipStop && ctrl.clockSourceSelect == CLKSRC_INT && ctrl.referenceSelect
    && ctrl.lowPowerBit && !debugActive |=> currentMode == MMCG_LOW_POWER_INTERNAL_MODE) else $error("low power internal missed");
  low_power_external_mode_debug_a: assert property (currentMode == MMCG_LOW_POWER_EXTERNAL_MODE && !chipStop && debugActive && ctrl.loopSelect
    && ctrl.clockSourceSelect == CLKSRC_EXT && ctrl.lowPowerBit |=> currentMode == MMCG_PBE) else $error("debug exit");
  bus_div_a: assert property ($past(resetn) && !$past(chipStop) |-> busDividerOut == $past(ctrl.busDivider))
    else $error("bus divider late");
  ref_hold_a: assert property ((!externalReadyPin)[*8] |=> !$fell(referenceStatus))
    else $error("reference status fell early");
  src_int_a: assert property ((!chipStop && ctrl.clockSourceSelect == CLKSRC_INT && ctrl.referenceSelect)[*6]
    |-> clockSourceStatus == CLKSRC_INT && outputSourceSel == CLKSRC_INT) else $error("internal switch late");
  stop_gates_a: assert property ((chipStop && $stable(ctrl))[*4] |-> !generatorClockEnable && !loopCtrl.fllEnable
    && !loopCtrl.pllEnable && internalRefClockEnable == (ctrl.internalRefOutEnable && ctrl.internalRefStopEnable))
    else $error("stop gating wrong");
  vco_mult_a: assert property ((!chipStop && $stable(ctrl) && ctrl.vcoMultiplierField inside {[1:10]})[*4]
    |-> loopCtrl.pllMultiplier == {ctrl.vcoMultiplierField, 2'b00}) else $error("multiplier wrong");
  trim_keep_a: assert property (disable iff (!powerOnResetn) !trimWrite |=> $stable(trimOut) && $stable(fineTrimOut))
    else $error("trim lost");
  // ----
  // coverage
  // ----
  cover property (currentMode == MMCG_PEE);
  cover property (chipStop && internalRefClockEnable);
  cover property (lossOfClockFlag);
endmodule
bind mmcg_mode_ctrl mmcg_checker mmcg_checker_i (.*);

/* verification/tb_top.sv */
// self-checking bench walking the clock generator through its modes
// assumes the oscillator model and the bound checker beside the design
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mmcg_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, powerOnResetn = 1'b0, debugActive = 1'b0, chipStop = 1'b0;
  logic trimWrite = 1'b0, fineTrimWriteValue = 1'b0, loopLockPin = 1'b0, oscRun = 1'b1, oscStable = 1'b0;
  logic [7:0] trimWriteValue = 8'h00;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h5, 4'hA, 4'hB};
  mmcg_ctrl_t ctrl;
  wire logic externalRefPin, externalReadyPin;
  mmcg_loop_t loopCtrl;
  logic [1:0] outputSourceSel, busDividerOut, clockSourceStatus;
  logic debugLinkClockEnable, internalRefClockEnable, externalRefClockEnable, generatorClockEnable;
  logic [7:0] trimOut;
  logic fineTrimOut, outputFollowsTrim, referenceStatus, loopSelectStatus, lossOfClockReset, lossOfClockFlag;
  mmcg_mode_t currentMode;
  int mismatches = 0, cmp_count = 0, cycles = 0;

  mmcg_mode_ctrl mmcg_mode_ctrl_i (.*);
  mmcg_ext_osc mmcg_ext_osc_i (.oscRun(oscRun), .oscStable(oscStable), .externalRefPin(externalRefPin),
    .externalReadyPin(externalReadyPin));

  initial forever #4 ref_clk = ~ref_clk;
  // ----
  // tasks
  // ----
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task setm(input logic [1:0] s, input logic r, input logic l, input logic p);
    @(posedge ref_clk);
    ctrl.clockSourceSelect <= s;
    ctrl.referenceSelect <= r;
    ctrl.loopSelect <= l;
    ctrl.lowPowerBit <= p;
    ctrl.referenceDivider <= r ? 3'h0 : {1'b0, ~l, 1'b1};
  endtask
  task drv(input logic d, input logic s);
    @(posedge ref_clk);
    debugActive <= d;
    chipStop <= s;
  endtask
  task summarize;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a hang ends in the same report
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize;
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    ctrl = '0;
    ctrl.referenceSelect = 1'b1;
    ctrl.busDivider = 2'h1;
    ctrl.vcoMultiplierField = 4'h1;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    powerOnResetn <= 1'b1;
    cyc(2);
    chk("mode", MMCG_FEI, currentMode);
    chk("refstat", 8'h01, referenceStatus);
    chk("trim", TRIM_RESET, trimOut);
    chk("fine_trim", {7'h00, FINETRIM_RESET}, fineTrimOut);
    @(posedge ref_clk);
    ctrl.busDivider <= 2'h3;
    trimWrite <= 1'b1;
    trimWriteValue <= 8'h3C;
    fineTrimWriteValue <= 1'b1;
    @(posedge ref_clk);
    trimWrite <= 1'b0;
    #1 chk("busdiv", 8'h03, busDividerOut);
    setm(CLKSRC_INT, 1'b1, 1'b0, 1'b0);
    cyc(6);
    chk("mode", MMCG_FBI, currentMode);
    chk("clock_source_status", CLKSRC_INT, clockSourceStatus);
    chk("follow", 8'h01, outputFollowsTrim);
    setm(CLKSRC_INT, 1'b1, 1'b0, 1'b1);
    cyc(3);
    chk("mode", MMCG_LOW_POWER_INTERNAL_MODE, currentMode);
    chk("loops", 8'h00, {loopCtrl.fllEnable, loopCtrl.pllEnable});
    chk("link", 8'h00, debugLinkClockEnable);
    drv(1'b1, 1'b0);
    cyc(3);
    chk("mode", MMCG_FBI, currentMode);
    chk("link", 8'h01, debugLinkClockEnable);
    setm(CLKSRC_INT, 1'b1, 1'b0, 1'b0);
    drv(1'b0, 1'b0);
    // external source not yet settled: the old clock has to stay
    setm(CLKSRC_EXT, 1'b0, 1'b0, 1'b0);
    cyc(10);
    chk("clock_source_status", CLKSRC_INT, clockSourceStatus);
    chk("refstat", 8'h01, referenceStatus);
    @(posedge ref_clk);
    oscStable <= 1'b1;
    cyc(10);
    chk("mode", MMCG_FBE, currentMode);
    chk("clock_source_status", CLKSRC_EXT, clockSourceStatus);
    chk("refstat", 8'h00, referenceStatus);
    chk("fll", 8'h01, loopCtrl.fllEnable);
    chk("link", 8'h01, debugLinkClockEnable);
    chk("follow", 8'h00, outputFollowsTrim);
    setm(CLKSRC_EXT, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      ctrl.vcoMultiplierField <= codes[i];
      cyc(4);
      chk("mult", (codes[i] == 4'h0 || codes[i] > 4'hA) ? 8'h28 : {2'h0, codes[i], 2'h0}, loopCtrl.pllMultiplier);
    end
    chk("mode", MMCG_PBE, currentMode);
    chk("fll", 8'h00, loopCtrl.fllEnable);
    chk("loopst", 8'h01, loopSelectStatus);
    chk("pllext", 8'h01, loopCtrl.pllUsesExternal);
    drv(1'b1, 1'b0);
    cyc(3);
    chk("dcolink", 8'h01, loopCtrl.dcoHalfLink);
    drv(1'b0, 1'b0);
    @(posedge ref_clk);
    loopLockPin <= 1'b1;
    setm(CLKSRC_LOOP, 1'b0, 1'b1, 1'b0);
    cyc(8);
    chk("mode", MMCG_PEE, currentMode);
    chk("clock_source_status", CLKSRC_LOOP, clockSourceStatus);
    setm(CLKSRC_EXT, 1'b0, 1'b1, 1'b0);
    cyc(8);
    setm(CLKSRC_EXT, 1'b0, 1'b1, 1'b1);
    cyc(3);
    chk("mode", MMCG_LOW_POWER_EXTERNAL_MODE, currentMode);
    drv(1'b1, 1'b0);
    cyc(3);
    chk("mode", MMCG_PBE, currentMode);
    drv(1'b0, 1'b0);
    @(posedge ref_clk);
    ctrl.internalRefOutEnable <= 1'b1;
    ctrl.internalRefStopEnable <= 1'b1;
    ctrl.externalRefOutEnable <= 1'b1;
    cyc(3);
    drv(1'b0, 1'b1);
    cyc(4);
    chk("genclk", 8'h00, generatorClockEnable);
    chk("link", 8'h00, debugLinkClockEnable);
    chk("irclk", 8'h01, internalRefClockEnable);
    chk("erclk", 8'h01, externalRefClockEnable);
    @(posedge ref_clk);
    ctrl.internalRefStopEnable <= 1'b0;
    cyc(4);
    chk("irclk", 8'h00, internalRefClockEnable);
    drv(1'b0, 1'b0);
    setm(CLKSRC_EXT, 1'b0, 1'b0, 1'b0);
    cyc(4);
    setm(CLKSRC_LOOP, 1'b0, 1'b0, 1'b0);
    cyc(8);
    chk("mode", MMCG_FEE, currentMode);
    chk("fllext", 8'h01, loopCtrl.fllUsesExternal);
    // source dies: long threshold not reached yet, then the short one trips
    @(posedge ref_clk);
    ctrl.clockMonitorEnable <= 1'b1;
    ctrl.rangeHigh <= 1'b0;
    oscRun <= 1'b0;
    cyc(80);
    chk("locrst", 8'h00, lossOfClockReset);
    @(posedge ref_clk);
    ctrl.rangeHigh <= 1'b1;
    cyc(4);
    chk("locrst", 8'h01, lossOfClockReset);
    chk("locflag", 8'h01, lossOfClockFlag);
    @(posedge ref_clk);
    resetn <= 1'b0;
    ctrl.clockMonitorEnable <= 1'b0;
    oscRun <= 1'b1;
    cyc(2);
    @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(2);
    chk("trim", 8'h3C, trimOut);
    chk("fine_trim", 8'h01, fineTrimOut);
    chk("locflag", 8'h01, lossOfClockFlag);
    summarize;
  end
endmodule
